// ### hw/eam_monitor.sv
`timescale 1ns/1ps
// How it works
// - ten-bit far-end block error count; wrap raises its overflow flag
// - error flags clear on read unless error hold enabled, then per second
// - with hold, errors of one second show steady through the next
// - frame-bit error flag per direction, receive and transmit
// - multiframe error flag only in E1 with CRC4 framing
// - signaling error flag only in E1 with CAS framing
// - CRC error flag only in T1 ESF and E1 CRC4 modes
// - density violation on over 15 zeros or ones under 12.5 percent
// - each alarm has live status, enable bit and sticky status
// - alarm flags clear on read unless alarm hold per second
// - E1 frame loss ORs three alignment losses; T1 equals basic loss
// - two-bit cause names which alignment loss started E1 frame loss
// - four-bit frame loss count at 05A; wrap flags overflow
// - T1 integration over two seconds; loss count unaffected
// - signal loss after 100 zeros T1 or 32 zeros E1
// - signal loss clears after good 114-bit window from a pulse
// - automatic option sends alarm indication while signal lost
// - amplitude loss: analog threshold, or digital clock low 125 us
// - T1 alarm indication: frame loss and at most 4 zeros in 4632 bits
// - E1 alarm indication: basic loss and two 512-bit blocks of few zeros
// - severe frame live status, two-bit count, overflow flag
// - severe frame windows: T1 framer-marked 3 ms, E1 free 2 ms
// - counters clear on read unless count hold latches per second
module eam_monitor
  import eam_pkg::*;
#(
  parameter int INTEG_CYCLES = INTEG_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // decoded receive stream
  input  wire logic       rx_bit_en,
  input  wire logic       rx_bit,
  // framer states and events
  input  wire logic       basic_frame_align_lost,
  input  wire logic       multiframe_align_lost,
  input  wire logic       signaling_frame_align_lost,
  input  wire logic       frame_bit_error_rx,
  input  wire logic       multiframe_align_error_rx,
  input  wire logic       signaling_align_error_rx,
  input  wire logic       crc_block_error_rx,
  input  wire logic       frame_bit_error_tx,
  input  wire logic       multiframe_align_error_tx,
  input  wire logic       signaling_align_error_tx,
  input  wire logic       crc_block_error_tx,
  input  wire logic       far_end_block_error,
  input  wire logic       frame_realign_change,
  input  wire logic       severe_window_close,
  input  wire logic       one_sec_tick,
  // line pins and mode
  input  wire logic       receive_clock_input,
  input  wire logic       amplitude_below_thr,
  input  wire logic       digital_receive_select,
  // transmitter control
  output logic            tx_send_alarm_ind
);

  logic [7:0] ctrl, rxcfg, receive_alarm_config, hold_cfg, transmit_alarm_config, a1_ie;
  logic [7:0] st_v [5];
  logic [7:0] ev [5];
  logic [4:0] st_hold;
  logic [9:0] shown [4];
  logic [3:0] cnt_inc, cnt_rd, cnt_ovf;
  logic [1:0] fe_hi;
  logic       t1, esf, e1_crc, e1_cas;
  logic       floss_raw, fl_int, frame_loss;
  logic [1:0] loss_cause;
  logic [31:0] icnt;
  logic [7:0] zrun;
  logic       zero_trip, dens_evt;
  logic [5:0] dblk;
  logic [6:0] dones;
  logic       sig_loss, lw_act;
  logic [6:0] lw_cnt, lw_ones;
  logic [1:0] pin_in, pin_f;
  logic [2:0] sync_q [2];
  logic [11:0] ck_low;
  logic       amp_loss;
  logic [12:0] aw_cnt, aw_zeros;
  logic       aw_last, aw_ok, aw_prev, aind_q, aind;
  logic [11:0] sw_cnt;
  logic [1:0] sw_errs;
  logic       sw_close, severe;
  logic [3:0] prev_alm;
  logic       prev_raw, prev_severe, prev_basic;

  function automatic logic hit(input logic [7:0] a);
    hit = reg_rd && (reg_addr == a);
  endfunction

  assign t1     = ctrl[CTRL_T1];
  assign esf    = (ctrl[3:0] == 4'h1) || (ctrl[3:2] == 2'h3);
  assign e1_crc = !t1 && ctrl[CTRL_CRC];
  assign e1_cas = !t1 && ctrl[CTRL_CAS];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl     <= RST_VAL;
      rxcfg    <= RST_VAL;
      receive_alarm_config     <= RST_VAL;
      hold_cfg <= RST_VAL;
      transmit_alarm_config     <= RST_VAL;
      a1_ie    <= RST_VAL;
    end else if (reg_wr) begin
      case (reg_addr)
        A_CTRL:    ctrl <= reg_wdata;
        A_RXCFG:   rxcfg <= reg_wdata;
        A_RECEIVE_ALARM_CONFIG:    receive_alarm_config <= reg_wdata;
        A_HOLD:    hold_cfg <= reg_wdata;
        A_TRANSMIT_ALARM_CONFIG:    transmit_alarm_config <= reg_wdata;
        A_ALARM1_STATUS_IE: a1_ie <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // pins: three stages, accept once stages two and three agree
  assign pin_in = {amplitude_below_thr, receive_clock_input};
  for (genvar p = 0; p < 2; p++) begin : g_sync
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        sync_q[p] <= 3'h0;
        pin_f[p]  <= 1'b0;
      end else begin
        sync_q[p] <= {sync_q[p][1:0], pin_in[p]};
        if (sync_q[p][1] == sync_q[p][2])
          pin_f[p] <= sync_q[p][2];
      end
    end
  end

  // frame loss, integration and cause
  assign floss_raw = t1 ? basic_frame_align_lost :
                     (basic_frame_align_lost | multiframe_align_lost |
                      signaling_frame_align_lost);
  assign frame_loss = (t1 && receive_alarm_config[RECEIVE_ALARM_CONFIG_INTG]) ? fl_int : floss_raw;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fl_int <= 1'b0;
      icnt   <= 32'h0;
    end else if (floss_raw == fl_int) begin
      icnt <= 32'h0;
    end else if (icnt == 32'(INTEG_CYCLES - 1)) begin
      fl_int <= floss_raw;
      icnt   <= 32'h0;
    end else begin
      icnt <= icnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loss_cause <= 2'h0;
      prev_raw   <= 1'b0;
    end else begin
      prev_raw <= floss_raw;
      if (!t1 && floss_raw && !prev_raw)
        loss_cause <= basic_frame_align_lost ? 2'h1 :
                      multiframe_align_lost ? 2'h2 : 2'h3;
    end
  end

  // zero runs and density
  assign zero_trip = rx_bit_en && !rx_bit &&
                     (zrun == 8'(t1 ? LOS_T1_ZEROS - 1 : LOS_E1_ZEROS - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zrun     <= 8'h0;
      dblk     <= 6'h0;
      dones    <= 7'h0;
      dens_evt <= 1'b0;
    end else begin
      dens_evt <= 1'b0;
      if (rx_bit_en) begin
        zrun  <= rx_bit ? 8'h0 : (zrun == 8'hFF ? zrun : zrun + 8'h1);
        dblk  <= dblk + 6'h1;
        dones <= (dblk == 6'h0) ? 7'(rx_bit) : dones + 7'(rx_bit);
        if (!rx_bit && zrun == 8'(DENS_RUN))
          dens_evt <= 1'b1;
        if (dblk == 6'(DENS_BLK - 1) && (dones + 7'(rx_bit)) < 7'(DENS_MIN))
          dens_evt <= 1'b1;
      end
    end
  end

  // signal loss and its recovery window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sig_loss <= 1'b0;
      lw_act   <= 1'b0;
      lw_cnt   <= 7'h0;
      lw_ones  <= 7'h0;
    end else if (zero_trip) begin
      sig_loss <= 1'b1;
      lw_act   <= 1'b0;
    end else if (rx_bit_en && sig_loss) begin
      if (!lw_act) begin
        lw_act  <= rx_bit;
        lw_cnt  <= 7'h1;
        lw_ones <= 7'h1;
      end else if (lw_cnt == 7'(LOS_WIN - 1)) begin
        lw_act <= 1'b0;
        if ((lw_ones + 7'(rx_bit)) >= 7'(LOS_MIN_ONES))
          sig_loss <= 1'b0;
      end else begin
        lw_cnt  <= lw_cnt + 7'h1;
        lw_ones <= lw_ones + 7'(rx_bit);
      end
    end
  end

  assign tx_send_alarm_ind = transmit_alarm_config[TRANSMIT_ALARM_CONFIG_AUTO] && sig_loss;

  // amplitude loss: clock stuck low in digital mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      ck_low <= 12'h0;
    else if (pin_f[0])
      ck_low <= 12'h0;
    else if (ck_low != 12'(ALOS_CYC))
      ck_low <= ck_low + 12'h1;
  end
  assign amp_loss = digital_receive_select ? (ck_low == 12'(ALOS_CYC)) : pin_f[1];

  // alarm indication: ones-rich blocks; >= ends a block left long by a rate change
  assign aw_last = rx_bit_en &&
                   (aw_cnt >= 13'(t1 ? AIND_T1_BITS - 1 : AIND_E1_BITS - 1));
  assign aw_ok   = (aw_zeros + 13'(!rx_bit)) <=
                   13'(t1 ? AIND_T1_MAXZ : AIND_E1_MAXZ);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_cnt   <= 13'h0;
      aw_zeros <= 13'h0;
      aw_prev  <= 1'b0;
      aind_q   <= 1'b0;
    end else if (aw_last) begin
      aw_cnt   <= 13'h0;
      aw_zeros <= 13'h0;
      aw_prev  <= aw_ok;
      aind_q   <= t1 ? aw_ok : (aw_ok && aw_prev);
    end else if (rx_bit_en) begin
      aw_cnt   <= aw_cnt + 13'h1;
      aw_zeros <= aw_zeros + 13'(!rx_bit);
    end
  end
  assign aind = aind_q && (t1 ? floss_raw : basic_frame_align_lost);

  // severe frames: framer-marked windows in T1, free 2 ms in E1
  assign sw_close = t1 ? severe_window_close :
                    (rx_bit_en && sw_cnt == 12'(SEV_E1_BITS - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_cnt  <= 12'h0;
      sw_errs <= 2'h0;
      severe  <= 1'b0;
    end else begin
      if (rx_bit_en)
        sw_cnt <= sw_cnt + 12'h1;
      if (sw_close) begin
        severe  <= ({1'b0, sw_errs} + 3'(frame_bit_error_rx)) >= 3'(SEV_ERRS);
        sw_errs <= 2'h0;
      end else if (frame_bit_error_rx && sw_errs != 2'h3) begin
        sw_errs <= sw_errs + 2'h1;
      end
    end
  end

  // rising edges for sticky alarm and counter events
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_alm    <= 4'h0;
      prev_severe <= 1'b0;
      prev_basic  <= 1'b0;
    end else begin
      prev_alm    <= {aind, amp_loss, sig_loss, frame_loss};
      prev_severe <= severe;
      prev_basic  <= basic_frame_align_lost;
    end
  end

  always_comb begin
    ev[0] = 8'h0;
    ev[0][B_FLOSS] = frame_loss && !prev_alm[0];
    ev[0][B_SLOSS] = sig_loss && !prev_alm[1];
    ev[0][B_AMPL]  = amp_loss && !prev_alm[2];
    ev[0][B_AIND]  = aind && !prev_alm[3];
    ev[0][B_DENS]  = dens_evt;
    ev[1] = 8'h0;
    ev[1][B_ONESEC] = one_sec_tick;
    ev[2] = {4'h0, crc_block_error_rx && (esf && t1 || e1_crc),
             signaling_align_error_rx && e1_cas,
             multiframe_align_error_rx && e1_crc,
             frame_bit_error_rx};
    ev[3] = {4'h0, cnt_ovf};
    ev[4] = {4'h0, crc_block_error_tx && (esf && t1 || e1_crc),
             signaling_align_error_tx && e1_cas,
             multiframe_align_error_tx && e1_crc,
             frame_bit_error_tx};
  end

  assign st_hold = {{3{hold_cfg[HOLD_ERR]}}, {2{hold_cfg[HOLD_ALM]}}};

  // sticky status: clear on read, or per-second snapshot under hold
  for (genvar g = 0; g < 5; g++) begin : g_st
    logic [7:0] st, acc;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        st  <= 8'h0;
        acc <= 8'h0;
      end else if (st_hold[g]) begin
        if (one_sec_tick) begin
          st  <= acc | ev[g];
          acc <= 8'h0;
        end else begin
          acc <= acc | ev[g];
        end
      end else begin
        st  <= (hit(ST_ADDR[g]) ? 8'h0 : st) | ev[g];
        acc <= 8'h0;
      end
    end
    assign st_v[g] = st;
  end

  // event counters
  assign cnt_inc = {frame_realign_change, severe && !prev_severe,
                    basic_frame_align_lost && !prev_basic, far_end_block_error};
  assign cnt_rd  = hold_cfg[HOLD_CNT] ? 4'h0 :
                   {{3{hit(A_FRAME_ALARM_EVENT_COUNTER)}}, hit(A_FE_LO)};

  for (genvar g = 0; g < 4; g++) begin : g_cnt
    localparam logic [9:0] MAXV = 10'((1 << CW[g]) - 1);
    logic [9:0] c, s, base, nxt;
    always_comb begin
      base = cnt_rd[g] ? 10'h0 : c;
      nxt  = base;
      if (cnt_inc[g])
        nxt = (base == MAXV) ? 10'h0 : base + 10'h1;
    end
    assign cnt_ovf[g] = cnt_inc[g] && (base == MAXV);
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        c <= 10'h0;
        s <= 10'h0;
      end else if (hold_cfg[HOLD_CNT] && one_sec_tick) begin
        s <= nxt;
        c <= 10'h0;
      end else begin
        c <= nxt;
      end
    end
    assign shown[g] = hold_cfg[HOLD_CNT] ? s : c;
  end

  // read data; upper far-end bits frozen at the low-byte read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h0;
      fe_hi     <= 2'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        A_CTRL:    reg_rdata <= ctrl;
        A_ALARM1_STATUS_IS: reg_rdata <= st_v[0];
        A_ALM2_IS: reg_rdata <= st_v[1];
        A_ERR_IS:  reg_rdata <= st_v[2];
        A_OVF_IS:  reg_rdata <= st_v[3];
        A_PAT_IS:  reg_rdata <= st_v[4];
        A_ALARM1_STATUS_IE: reg_rdata <= a1_ie;
        A_RXCFG:   reg_rdata <= rxcfg;
        A_RECEIVE_ALARM_CONFIG:    reg_rdata <= receive_alarm_config;
        A_HOLD:    reg_rdata <= hold_cfg;
        A_TRANSMIT_ALARM_CONFIG:    reg_rdata <= transmit_alarm_config;
        A_ALARM1_STATUS:    reg_rdata <= {3'h0, (zrun > 8'(DENS_RUN)), aind, amp_loss,
                                 sig_loss, frame_loss};
        A_ALARM3_STATUS:    reg_rdata <= {2'h0, severe, loss_cause, signaling_frame_align_lost,
                                 multiframe_align_lost, basic_frame_align_lost};
        A_FE_LO: begin
          reg_rdata <= shown[0][7:0];
          fe_hi     <= shown[0][9:8];
        end
        A_FE_HI:   reg_rdata <= {6'h0, fe_hi};
        A_FRAME_ALARM_EVENT_COUNTER:    reg_rdata <= {shown[3][1:0], shown[2][1:0], shown[1][3:0]};
        default:   reg_rdata <= 8'h0;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_zero_run;
    zero_trip;
  endsequence
  sequence s_loss_held;
    sig_loss [*2];
  endsequence

  loss_declare_a: assert property (s_zero_run |=> s_loss_held)
    else $error("signal loss not declared on zero run");
  loss_recover_a: assert property ($fell(sig_loss) |-> $past(lw_act) &&
    $past(lw_cnt) == 7'(LOS_WIN - 1))
    else $error("signal loss cleared outside a full window");
  auto_send_a: assert property (transmit_alarm_config[TRANSMIT_ALARM_CONFIG_AUTO] && $rose(sig_loss) |=> tx_send_alarm_ind)
    else $error("auto alarm indication not sent");
  overflow_flag_a: assert property (cnt_ovf[0] && !st_hold[3] |=> st_v[3][0])
    else $error("far-end overflow not flagged");
  wrap_zero_a: assert property (cnt_inc[1] && g_cnt[1].c == 10'hF && !cnt_rd[1] &&
    !hold_cfg[HOLD_CNT] |=> g_cnt[1].c == 10'h0)
    else $error("frame loss count did not wrap");
  read_race_a: assert property (!st_hold[2] && hit(A_ERR_IS) && ev[2][0] |=> st_v[2][0])
    else $error("event lost in clearing read");
  read_clear_a: assert property (!st_hold[2] && hit(A_ERR_IS) && ev[2] == 8'h0 |=>
    st_v[2] == 8'h0)
    else $error("error status not cleared by read");
  hold_steady_a: assert property (st_hold[2] && !one_sec_tick |=> $stable(st_v[2]))
    else $error("held error status moved mid-second");
  e1_loss_or_a: assert property (!t1 && multiframe_align_lost |-> frame_loss)
    else $error("E1 frame loss missing multiframe loss");
  integ_time_a: assert property (t1 && receive_alarm_config[RECEIVE_ALARM_CONFIG_INTG] && $rose(fl_int) |->
    $past(icnt) == 32'(INTEG_CYCLES - 1) && $past(floss_raw))
    else $error("frame loss integrated early");
  dig_clock_a: assert property (digital_receive_select && $rose(amp_loss) |->
    $past(ck_low) == 12'(ALOS_CYC - 1))
    else $error("amplitude loss timing wrong");
  e1_aind_a: assert property (!t1 && $rose(aind) |-> basic_frame_align_lost)
    else $error("E1 alarm indication without basic loss");
  mf_gate_a: assert property (t1 |-> !ev[2][1])
    else $error("multiframe error flagged in T1");

endmodule

// ### hw/eam_pkg.sv
package eam_pkg;
  // register offsets
  localparam logic [7:0] A_CTRL    = 8'h01;
  localparam logic [7:0] A_ALARM1_STATUS_IS = 8'h04;
  localparam logic [7:0] A_ALM2_IS = 8'h05;
  localparam logic [7:0] A_ERR_IS  = 8'h06;
  localparam logic [7:0] A_OVF_IS  = 8'h07;
  localparam logic [7:0] A_PAT_IS  = 8'h0B;
  localparam logic [7:0] A_ALARM1_STATUS_IE = 8'h0C;
  localparam logic [7:0] A_RXCFG   = 8'h40;
  localparam logic [7:0] A_RECEIVE_ALARM_CONFIG    = 8'h45;
  localparam logic [7:0] A_HOLD    = 8'h46;
  localparam logic [7:0] A_ALARM1_STATUS    = 8'h47;
  localparam logic [7:0] A_ALARM3_STATUS    = 8'h49;
  localparam logic [7:0] A_FE_LO   = 8'h56;
  localparam logic [7:0] A_FE_HI   = 8'h57;
  localparam logic [7:0] A_FRAME_ALARM_EVENT_COUNTER    = 8'h5A;
  localparam logic [7:0] A_TRANSMIT_ALARM_CONFIG    = 8'h75;
  localparam logic [7:0] ST_ADDR [5] = '{A_ALARM1_STATUS_IS, A_ALM2_IS, A_ERR_IS, A_OVF_IS, A_PAT_IS};
  localparam logic [7:0] RST_VAL = 8'h00;
  // field positions
  localparam int CTRL_T1   = 7;
  localparam int CTRL_CAS  = 3;
  localparam int CTRL_CRC  = 2;
  localparam int HOLD_ERR  = 0;
  localparam int HOLD_ALM  = 1;
  localparam int HOLD_CNT  = 2;
  localparam int RECEIVE_ALARM_CONFIG_INTG = 0;
  localparam int TRANSMIT_ALARM_CONFIG_AUTO = 0;
  localparam int B_FLOSS   = 0;
  localparam int B_SLOSS   = 1;
  localparam int B_AMPL    = 2;
  localparam int B_AIND    = 3;
  localparam int B_DENS    = 4;
  localparam int B_ONESEC  = 7;
  localparam int B_SEVERE  = 5;
  // counters: far-end, frame-loss, severe frame, realign
  localparam int CW [4] = '{10, 4, 2, 2};
  // timing
  localparam int CLK_MHZ      = 25;
  localparam int LOS_T1_ZEROS = 100;
  localparam int LOS_E1_ZEROS = 32;
  localparam int LOS_WIN      = 114;
  localparam int LOS_MIN_ONES = (LOS_WIN + 7) / 8;
  localparam int DENS_RUN     = 15;
  localparam int DENS_BLK     = 64;
  localparam int DENS_MIN     = DENS_BLK / 8;
  localparam int AIND_T1_BITS = 4632;
  localparam int AIND_T1_MAXZ = 4;
  localparam int AIND_E1_BITS = 512;
  localparam int AIND_E1_MAXZ = 2;
  localparam int SEV_E1_MS    = 2;
  localparam int SEV_E1_BITS  = SEV_E1_MS * 2048;
  localparam int SEV_ERRS     = 2;
  localparam int ALOS_US      = 125;
  localparam int ALOS_CYC     = ALOS_US * CLK_MHZ;
  localparam int INTEG_MS     = 2000;
  localparam int INTEG_CYC    = INTEG_MS * CLK_MHZ * 1000;
endpackage

// ### test/eam_host.sv
`timescale 1ns/1ps
module eam_host (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // strobes move on the falling edge so the rising edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    // released data must not look like the last value
    reg_wdata = ~d;
  endtask
  // read data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule

// ### test/eam_monitor_test.sv
`timescale 1ns/1ps
module eam_monitor_test
  import eam_pkg::*;
;
  localparam logic [7:0] MD [5] = '{8'h8C, 8'h84, 8'h04, 8'h08, 8'h00};
  localparam logic [7:0] EX [5] = '{8'h09, 8'h01, 8'h0B, 8'h05, 8'h01};
  localparam int         RUN [2] = '{32, 100};
  localparam logic [7:0] RM [2] = '{8'h00, 8'h8C};
  logic        core_clk, rst, wr, rd, bit_en, rx_bit, fr_lost, mf_lost, sg_lost;
  logic        rck, amp, dig, tx_ais;
  logic [7:0]  addr, wdata, rdata, d;
  logic [11:0] ev;
  int          errors, cmp_count;

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  eam_monitor #(.INTEG_CYCLES(20)) u_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .rx_bit_en(bit_en), .rx_bit(rx_bit),
    .basic_frame_align_lost(fr_lost), .multiframe_align_lost(mf_lost),
    .signaling_frame_align_lost(sg_lost), .frame_bit_error_rx(ev[0]),
    .multiframe_align_error_rx(ev[1]), .signaling_align_error_rx(ev[2]),
    .crc_block_error_rx(ev[3]), .frame_bit_error_tx(ev[4]),
    .multiframe_align_error_tx(ev[5]), .signaling_align_error_tx(ev[6]),
    .crc_block_error_tx(ev[7]), .far_end_block_error(ev[8]),
    .frame_realign_change(ev[9]), .severe_window_close(ev[10]),
    .one_sec_tick(ev[11]), .receive_clock_input(rck), .amplitude_below_thr(amp),
    .digital_receive_select(dig), .tx_send_alarm_ind(tx_ais));

  eam_host u_host (
    .core_clk(core_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata));

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] g;
    u_host.rd(a, g);
    cmp(g & m, e);
  endtask
  task automatic fire(input logic [11:0] m, input int n);
    repeat (n) begin
      @(negedge core_clk);
      ev = m;
      @(negedge core_clk);
      ev = 12'h000;
    end
  endtask
  task automatic bits(input int n, input logic v);
    repeat (n) begin
      @(negedge core_clk);
      rx_bit = v;
      bit_en = 1'b1;
      @(negedge core_clk);
      bit_en = 1'b0;
    end
  endtask
  task automatic summarize();
    $display("compares=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    summarize();
  end

  initial begin
    {bit_en, rx_bit, fr_lost, mf_lost, sg_lost, amp, dig} = 7'h00;
    rck = 1'b1;
    ev = 12'h000;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    foreach (ST_ADDR[i]) chk(ST_ADDR[i], 8'hFF, RST_VAL);
    chk(A_CTRL, 8'hFF, RST_VAL);
    chk(8'h02, 8'hFF, 8'h00);
    u_host.wr(A_ALARM1_STATUS, 8'hFF);
    chk(A_ALARM1_STATUS, 8'h1F, 8'h00);
    u_host.wr(A_ALARM1_STATUS_IE, 8'h1F);
    chk(A_ALARM1_STATUS_IE, 8'hFF, 8'h1F);
    // five framer modes, both directions
    foreach (MD[i]) begin
      u_host.wr(A_CTRL, MD[i]);
      fire(12'h0FF, 1);
      chk(A_ERR_IS, 8'h0F, EX[i]);
      chk(A_PAT_IS, 8'h0F, EX[i]);
      chk(A_ERR_IS, 8'h0F, 8'h00);
    end
    fork
      u_host.rd(A_ERR_IS, d);
      fire(12'h001, 1);
    join
    chk(A_ERR_IS, 8'h01, 8'h01);
    u_host.wr(A_HOLD, 8'h01);
    fire(12'h001, 1);
    fire(12'h800, 1);
    chk(A_ERR_IS, 8'h01, 8'h01);
    chk(A_ERR_IS, 8'h01, 8'h01);
    fire(12'h800, 1);
    chk(A_ERR_IS, 8'h01, 8'h00);
    chk(A_ALM2_IS, 8'h80, 8'h80);
    u_host.wr(A_HOLD, 8'h00);
    fire(12'h100, 3);
    chk(A_FE_LO, 8'hFF, 8'h03);
    chk(A_FE_HI, 8'h03, 8'h00);
    chk(A_FE_LO, 8'hFF, 8'h00);
    chk(A_OVF_IS, 8'hFF, 8'h00);
    fire(12'h100, 1024);
    chk(A_OVF_IS, 8'h01, 8'h01);
    chk(A_FE_LO, 8'hFF, 8'h00);
    u_host.wr(A_HOLD, 8'h04);
    fire(12'h100, 2);
    fire(12'h800, 1);
    chk(A_FE_LO, 8'hFF, 8'h02);
    chk(A_FE_LO, 8'hFF, 8'h02);
    u_host.wr(A_HOLD, 8'h00);
    // signal loss at both line rates
    u_host.wr(A_TRANSMIT_ALARM_CONFIG, 8'h01);
    foreach (RUN[i]) begin
      u_host.wr(A_CTRL, RM[i]);
      bits(RUN[i] - 1, 1'b0);
      chk(A_ALARM1_STATUS, 8'h02, 8'h00);
      bits(1, 1'b0);
      chk(A_ALARM1_STATUS, 8'h02, 8'h02);
      cmp({7'h00, tx_ais}, 8'h01);
      bits(120, 1'b1);
      chk(A_ALARM1_STATUS, 8'h02, 8'h00);
      cmp({7'h00, tx_ais}, 8'h00);
    end
    chk(A_ALARM1_STATUS_IS, 8'h12, 8'h12);
    bits(15, 1'b0);
    chk(A_ALARM1_STATUS, 8'h10, 8'h00);
    bits(1, 1'b0);
    chk(A_ALARM1_STATUS, 8'h10, 8'h10);
    chk(A_ALARM1_STATUS_IS, 8'h10, 8'h10);
    bits(130, 1'b1);
    u_host.wr(A_CTRL, 8'h0C);
    mf_lost = 1'b1;
    chk(A_ALARM1_STATUS, 8'h01, 8'h01);
    chk(A_ALARM3_STATUS, 8'h1F, 8'h12);
    mf_lost = 1'b0;
    u_host.wr(A_CTRL, 8'h84);
    mf_lost = 1'b1;
    chk(A_ALARM1_STATUS, 8'h01, 8'h00);
    mf_lost = 1'b0;
    chk(A_FRAME_ALARM_EVENT_COUNTER, 8'hFF, 8'h00);
    repeat (17) begin
      fr_lost = 1'b1;
      repeat (2) @(negedge core_clk);
      fr_lost = 1'b0;
      repeat (2) @(negedge core_clk);
    end
    chk(A_FRAME_ALARM_EVENT_COUNTER, 8'h0F, 8'h01);
    chk(A_OVF_IS, 8'h02, 8'h02);
    u_host.wr(A_RECEIVE_ALARM_CONFIG, 8'h01);
    fr_lost = 1'b1;
    chk(A_ALARM1_STATUS, 8'h01, 8'h00);
    repeat (25) @(negedge core_clk);
    chk(A_ALARM1_STATUS, 8'h01, 8'h01);
    chk(A_FRAME_ALARM_EVENT_COUNTER, 8'h0F, 8'h01);
    u_host.wr(A_RECEIVE_ALARM_CONFIG, 8'h00);
    u_host.wr(A_CTRL, 8'h00);
    bits(1600, 1'b1);
    chk(A_ALARM1_STATUS, 8'h08, 8'h08);
    // T1: a block with five zeros drops the indication, a clean block restores it
    u_host.wr(A_CTRL, 8'h84);
    bits(5, 1'b0);
    bits(4600, 1'b1);
    chk(A_ALARM1_STATUS, 8'h08, 8'h00);
    bits(4632, 1'b1);
    chk(A_ALARM1_STATUS, 8'h08, 8'h08);
    fr_lost = 1'b0;
    u_host.wr(A_CTRL, 8'h84);
    // earlier frame-bit errors still sit in the window: close two to start clean
    fire(12'h400, 2);
    u_host.rd(A_FRAME_ALARM_EVENT_COUNTER, d);
    fire(12'h001, 1);
    fire(12'h400, 1);
    chk(A_ALARM3_STATUS, 8'h20, 8'h00);
    fire(12'h001, 3);
    fire(12'h401, 1);
    chk(A_ALARM3_STATUS, 8'h20, 8'h20);
    chk(A_FRAME_ALARM_EVENT_COUNTER, 8'h30, 8'h10);
    amp = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(A_ALARM1_STATUS, 8'h04, 8'h04);
    amp = 1'b0;
    dig = 1'b1;
    rck = 1'b0;
    repeat (3000) @(negedge core_clk);
    chk(A_ALARM1_STATUS, 8'h04, 8'h00);
    repeat (200) @(negedge core_clk);
    chk(A_ALARM1_STATUS, 8'h04, 8'h04);
    rck = 1'b1;
    summarize();
  end
endmodule
